/* File: src/bqsmx_pkg.sv */
// Shared constants, types and register map of the biquad, summer and mixer chain
package bqsmx_pkg;

  // Register pages and offsets, address is {page, register}
  localparam logic [7:0] PAGE_CFG = 8'h00;
  localparam logic [7:0] PAGE_BQ_LO = 8'h02;
  localparam logic [7:0] PAGE_BQ_HI = 8'h03;
  localparam logic [7:0] PAGE_MIX = 8'h04;
  localparam logic [7:0] REG_SUM_CFG = 8'h6B;
  localparam logic [7:0] REG_BQ_CFG = 8'h6C;
  localparam logic [7:0] REG_STATUS = 8'h6D;
  localparam logic [7:0] REG_COEF_FIRST = 8'h08;
  localparam logic [7:0] REG_BQ_LAST = 8'h7F;
  localparam logic [7:0] REG_MIX_LAST = 8'h47;

  // Field positions and reset values
  localparam int SUM_POS = 2;
  localparam int BQ_POS = 5;
  localparam int BUSY_POS = 0;
  localparam logic [1:0] SUM_RST = 2'b00;
  localparam logic [1:0] BQ_RST = 2'b10;
  localparam logic [1:0] SUM_OFF = 2'b00;
  localparam logic [1:0] BQ_OFF = 2'b00;
  localparam logic [1:0] BQ_ONE = 2'b01;
  localparam logic [1:0] BQ_TWO = 2'b10;

  // Pool sizes
  localparam int NUM_CH = 4;
  localparam int NUM_SECT = 12;
  localparam int NUM_TAPS = 5;
  localparam int BQ_WORDS = 60;
  localparam int MIX_WORDS = 16;
  localparam logic [6:0] BQ_PAGE_WORDS = 7'h1E;

  // Last section index for one, two and three sections per channel
  localparam logic [3:0] LAST_ONE = 4'h3;
  localparam logic [3:0] LAST_TWO = 4'h7;
  localparam logic [3:0] LAST_THREE = 4'hB;

  // Coefficient values
  localparam logic [31:0] COEF_UNITY = 32'h7FFFFFFF;
  localparam logic [31:0] COEF_ZERO = 32'h00000000;
  localparam logic [15:0] MIX_UNITY_MASK = 16'h8421;

  // Numerator tap 0 of each section resets to unity
  function automatic logic [BQ_WORDS-1:0] bq_unity_mask();
    logic [BQ_WORDS-1:0] m;
    m = '0;
    for (int s = 0; s < NUM_SECT; s++)
    begin
      m[s*NUM_TAPS] = 1'b1;
    end
    return m;
  endfunction
  localparam logic [BQ_WORDS-1:0] BQ_UNITY_MASK = bq_unity_mask();

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bqsmx_bus_s;

  // Four-channel sample frame
  typedef struct packed {
    logic [3:0][31:0] ch;
  } bqsmx_frame_s;

  // Engine states, Gray along the filtering path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MIX = 2'b01,
    ST_FILT = 2'b11,
    ST_DONE = 2'b10
  } bqsmx_state_e;

endpackage

/* File: src/bqsmx_coef_bank.sv */
// Byte-writable bank of 32-bit coefficient words
module bqsmx_coef_bank #(
  parameter int WORDS = 16,
  parameter logic [WORDS-1:0] UNITY_MASK = '0
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Byte write
  input wire logic wr_i,
  input wire logic [6:0] word_i,
  input wire logic [1:0] lane_i,
  input wire logic [7:0] byte_i,
  // Stored words
  output logic [WORDS-1:0][31:0] coef_o
);
  import bqsmx_pkg::*;

  logic [WORDS-1:0][31:0] next_coef;

  // Lane 0 is the most significant byte
  always_comb
  begin
    next_coef = coef_o;
    if (wr_i)
    begin
      next_coef[word_i][(5'd24 - {lane_i, 3'b000}) +: 8] = byte_i;
    end
  end

  // Reset gives flat unity response
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < WORDS; i++)
      begin
        coef_o[i] <= UNITY_MASK[i] ? COEF_UNITY : COEF_ZERO;
      end
    end
    else
    begin
      coef_o <= next_coef;
    end
  end

endmodule

/* File: src/bqsmx_mac.sv */
// Five-term signed multiply-accumulate in 1.31 with saturation
module bqsmx_mac (
  // Operands
  input wire logic [4:0][31:0] coef_i,
  input wire logic [4:0][31:0] smp_i,
  input wire logic [4:0] dbl_i,
  // Result
  output logic [31:0] res_o
);

  logic signed [63:0] prod;
  logic signed [67:0] term;
  logic signed [67:0] acc;

  // Four guard bits keep five doubled products from wrapping
  always_comb
  begin
    prod = '0;
    term = '0;
    acc = '0;
    for (int i = 0; i < 5; i++)
    begin
      prod = $signed(coef_i[i]) * $signed(smp_i[i]);
      term = 68'(prod);
      if (dbl_i[i])
      begin
        term = term <<< 1;
      end
      acc = acc + term;
    end
    // Drop 31 fraction bits, clamp instead of wrapping
    if (acc[67:62] != {6{acc[62]}})
    begin
      res_o = acc[67] ? 32'h80000000 : 32'h7FFFFFFF;
    end
    else
    begin
      res_o = acc[62:31];
    end
  end

endmodule

/* File: src/bqsmx_chain.sv */
// Record-path chain: pair averaging or 4x4 mixer, then a pool of biquad sections
// How it works
// - A pool of twelve programmable biquad sections serves the record path.
// - Section: numerator_tap0, 2*numerator_tap1, numerator_tap2 over 2^31 - 2*feedback_tap1 - feedback_tap2.
// - After reset every section passes the signal flat at unity gain.
// - Section coefficients are 32-bit signed two's complement.
// - Allocation field 00 bypasses all biquad filtering.
// - Field 01/10/11 gives one, two or three sections per channel; default 10.
// - Sections 1-6 at page 2 regs 8-127, 7-12 same on page 3.
// - Averaging 01: outputs 1 and 2 carry (in1 + in2) / 2.
// - Averaging 01: outputs 3 and 4 carry (in3 + in4) / 2.
// - Averaging 00 by default disables it; 10 and 11 are reserved.
// - Mixer acts only with averaging field zero; averaging wins otherwise.
// - Mixer 1 makes output 1 as weighted sum of all four inputs.
// - Mixers 2 to 4 do the same for outputs 2 to 4.
// - Mixer coefficients are signed 1.31 fixed point, 32 bits.
// - 0x7FFFFFFF passes at unity, zero mutes, values between attenuate.
// - A set sign bit inverts that input's polarity at the same magnitude; the code reads the word as two's complement instead.
//
// Our own choices: the register addresses and the plain strobed port.
module bqsmx_chain (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input bqsmx_pkg::bqsmx_bus_s bus_i,
  output logic [7:0] rdata_o,
  // Input sample stream
  input wire logic smp_valid_i,
  input bqsmx_pkg::bqsmx_frame_s smp_i,
  // Output sample stream
  output logic out_valid_o,
  output bqsmx_pkg::bqsmx_frame_s out_o,
  // Status
  output logic busy_o
);
  import bqsmx_pkg::*;

  // Decode signals
  logic [7:0] page;
  logic [7:0] rg;
  logic [7:0] off;
  logic bq_hit;
  logic mix_hit;
  logic [6:0] bq_word;
  logic [6:0] mix_word;

  // Configuration state
  logic [1:0] pair_average_sel;
  logic [1:0] bq_alloc;
  logic [1:0] next_pair_average_sel;
  logic [1:0] next_bq_alloc;
  logic [7:0] next_rdata;

  // Coefficient banks
  logic [BQ_WORDS-1:0][31:0] bq_w;
  logic [MIX_WORDS-1:0][31:0] mix_w;

  // Engine state
  bqsmx_state_e state;
  bqsmx_state_e next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  bqsmx_frame_s in_frame;
  bqsmx_frame_s next_in_frame;
  bqsmx_frame_s work;
  bqsmx_frame_s next_work;
  bqsmx_frame_s next_out;
  logic next_out_valid;
  logic [NUM_SECT-1:0][31:0] x1;
  logic [NUM_SECT-1:0][31:0] x2;
  logic [NUM_SECT-1:0][31:0] y1;
  logic [NUM_SECT-1:0][31:0] y2;
  logic [NUM_SECT-1:0][31:0] next_x1;
  logic [NUM_SECT-1:0][31:0] next_x2;
  logic [NUM_SECT-1:0][31:0] next_y1;
  logic [NUM_SECT-1:0][31:0] next_y2;

  // Arithmetic operands and results
  logic [4:0][31:0] mix_coef;
  logic [4:0][31:0] mix_smp;
  logic [31:0] mix_res;
  logic [4:0][31:0] bq_coef;
  logic [4:0][31:0] bq_smp;
  logic [31:0] bq_res;
  logic signed [32:0] pair_sum;
  logic [31:0] avg_res;
  logic [3:0] last_sect;

  // Address split and window checks for the coefficient pages
  always_comb
  begin
    page = bus_i.addr[15:8];
    rg = bus_i.addr[7:0];
    off = rg - REG_COEF_FIRST;
    bq_hit = (page == PAGE_BQ_LO || page == PAGE_BQ_HI) && rg >= REG_COEF_FIRST && rg <= REG_BQ_LAST;
    mix_hit = (page == PAGE_MIX) && rg >= REG_COEF_FIRST && rg <= REG_MIX_LAST;
    // Twenty bytes per section equals five words, so words run on across sections
    bq_word = {1'b0, off[7:2]} + ((page == PAGE_BQ_HI) ? BQ_PAGE_WORDS : 7'h00);
    mix_word = {3'b000, off[5:2]};
  end

  // Section pool: five words per section, twelve sections
  bqsmx_coef_bank #(
    .WORDS(BQ_WORDS),
    .UNITY_MASK(BQ_UNITY_MASK)
  ) u_bq_bank (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_i(bus_i.wr && bq_hit),
    .word_i(bq_word),
    .lane_i(off[1:0]),
    .byte_i(bus_i.wdata),
    .coef_o(bq_w)
  );

  // Mixer bank: word m*4+j weights input j into output m
  bqsmx_coef_bank #(
    .WORDS(MIX_WORDS),
    .UNITY_MASK(MIX_UNITY_MASK)
  ) u_mix_bank (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_i(bus_i.wr && mix_hit),
    .word_i(mix_word),
    .lane_i(off[1:0]),
    .byte_i(bus_i.wdata),
    .coef_o(mix_w)
  );

  // Configuration writes and read data, valid only in the cycle after the strobe
  always_comb
  begin
    next_pair_average_sel = pair_average_sel;
    next_bq_alloc = bq_alloc;
    next_rdata = 8'h00;
    if (bus_i.wr && page == PAGE_CFG && rg == REG_SUM_CFG)
    begin
      next_pair_average_sel = bus_i.wdata[SUM_POS +: 2];
    end
    if (bus_i.wr && page == PAGE_CFG && rg == REG_BQ_CFG)
    begin
      next_bq_alloc = bus_i.wdata[BQ_POS +: 2];
    end
    if (bus_i.rd)
    begin
      if (bq_hit)
      begin
        next_rdata = bq_w[bq_word][(5'd24 - {off[1:0], 3'b000}) +: 8];
      end
      else if (mix_hit)
      begin
        next_rdata = mix_w[mix_word][(5'd24 - {off[1:0], 3'b000}) +: 8];
      end
      else if (page == PAGE_CFG && rg == REG_SUM_CFG)
      begin
        next_rdata[SUM_POS +: 2] = pair_average_sel;
      end
      else if (page == PAGE_CFG && rg == REG_BQ_CFG)
      begin
        next_rdata[BQ_POS +: 2] = bq_alloc;
      end
      else if (page == PAGE_CFG && rg == REG_STATUS)
      begin
        next_rdata[BUSY_POS] = busy_o;
      end
    end
  end

  // Register file state
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pair_average_sel <= SUM_RST;
      bq_alloc <= BQ_RST;
      rdata_o <= 8'h00;
    end
    else
    begin
      pair_average_sel <= next_pair_average_sel;
      bq_alloc <= next_bq_alloc;
      rdata_o <= next_rdata;
    end
  end

  // Mixer operands for output channel cnt
  always_comb
  begin
    mix_coef = '0;
    mix_smp = '0;
    for (int j = 0; j < NUM_CH; j++)
    begin
      mix_coef[j] = mix_w[{cnt[1:0], 2'(j)}];
      mix_smp[j] = in_frame.ch[j];
    end
  end

  bqsmx_mac u_mix_mac (
    .coef_i(mix_coef),
    .smp_i(mix_smp),
    .dbl_i(5'h00),
    .res_o(mix_res)
  );

  // Pair average; 33 bits hold the sum so halving cannot overflow
  always_comb
  begin
    if (cnt[1])
    begin
      pair_sum = $signed({in_frame.ch[2][31], in_frame.ch[2]}) + $signed({in_frame.ch[3][31], in_frame.ch[3]});
    end
    else
    begin
      pair_sum = $signed({in_frame.ch[0][31], in_frame.ch[0]}) + $signed({in_frame.ch[1][31], in_frame.ch[1]});
    end
    avg_res = pair_sum[32:1];
  end

  // Section cnt: three numerator and two feedback taps against x, x1, x2, y1, y2
  always_comb
  begin
    bq_coef = '0;
    for (int t = 0; t < NUM_TAPS; t++)
    begin
      bq_coef[t] = bq_w[NUM_TAPS * int'(cnt) + t];
    end
    bq_smp[0] = work.ch[cnt[1:0]];
    bq_smp[1] = x1[cnt];
    bq_smp[2] = x2[cnt];
    bq_smp[3] = y1[cnt];
    bq_smp[4] = y2[cnt];
  end

  // Doubled numerator_tap1 and feedback_tap1; feedback adds as 2^31 divides out
  bqsmx_mac u_bq_mac (
    .coef_i(bq_coef),
    .smp_i(bq_smp),
    .dbl_i(5'b01010),
    .res_o(bq_res)
  );

  // Highest section index used by the current allocation
  always_comb
  begin
    unique case (bq_alloc)
      BQ_ONE: last_sect = LAST_ONE;
      BQ_TWO: last_sect = LAST_TWO;
      default: last_sect = LAST_THREE;
    endcase
  end

  // Engine: one mix step per channel, then one section per cycle
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_in_frame = in_frame;
    next_work = work;
    next_out = out_o;
    next_out_valid = 1'b0;
    next_x1 = x1;
    next_x2 = x2;
    next_y1 = y1;
    next_y2 = y2;
    unique case (state)
      ST_IDLE:
      begin
        // Samples arriving while busy are dropped, not queued
        if (smp_valid_i)
        begin
          next_in_frame = smp_i;
          next_cnt = 4'h0;
          next_state = ST_MIX;
        end
      end
      ST_MIX:
      begin
        if (pair_average_sel != SUM_OFF)
        begin
          next_work.ch[cnt[1:0]] = avg_res;
        end
        else
        begin
          next_work.ch[cnt[1:0]] = mix_res;
        end
        if (cnt == 4'h3)
        begin
          next_cnt = 4'h0;
          next_state = (bq_alloc == BQ_OFF) ? ST_DONE : ST_FILT;
        end
        else
        begin
          next_cnt = cnt + 4'h1;
        end
      end
      ST_FILT:
      begin
        // Section k serves channel k mod 4, so each channel sees ascending order
        next_x2[cnt] = x1[cnt];
        next_x1[cnt] = work.ch[cnt[1:0]];
        next_y2[cnt] = y1[cnt];
        next_y1[cnt] = bq_res;
        next_work.ch[cnt[1:0]] = bq_res;
        if (cnt == last_sect)
        begin
          next_state = ST_DONE;
        end
        else
        begin
          next_cnt = cnt + 4'h1;
        end
      end
      ST_DONE:
      begin
        next_out = work;
        next_out_valid = 1'b1;
        next_state = ST_IDLE;
      end
    endcase
  end

  // Engine registers
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      in_frame <= '0;
      work <= '0;
      out_o <= '0;
      out_valid_o <= 1'b0;
      x1 <= '0;
      x2 <= '0;
      y1 <= '0;
      y2 <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      in_frame <= next_in_frame;
      work <= next_work;
      out_o <= next_out;
      out_valid_o <= next_out_valid;
      x1 <= next_x1;
      x2 <= next_x2;
      y1 <= next_y1;
      y2 <= next_y2;
    end
  end

  assign busy_o = (state != ST_IDLE);

endmodule

/* File: dv/bqsmx_host.sv */
// Host model: register port master that loads configuration and coefficients
module bqsmx_host (
  // Clock
  input wire logic sys_clk_i,
  // Register port
  output bqsmx_pkg::bqsmx_bus_s bus_o,
  input wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  import bqsmx_pkg::*;

  // Idle port from time zero
  initial bus_o = '0;

  // One-cycle write strobe; gap cycle avoids double drive at one edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    bus_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_i);
    bus_o <= '0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    bus_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk_i);
    bus_o <= '0;
    #1;
    d = rdata_i;
  endtask

  // Coefficient as four bytes, top byte at the lowest register
  task automatic wr32(input logic [15:0] a, input logic [31:0] v);
    for (int b = 0; b < 4; b++)
    begin
      wr(a + 16'(b), v[31-8*b -: 8]);
    end
  endtask
endmodule

/* File: dv/bqsmx_checker.sv */
// Port-level assertions for the biquad, summer and mixer chain
module bqsmx_checker (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Watched ports
  input bqsmx_pkg::bqsmx_bus_s bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic smp_valid_i,
  input wire logic out_valid_o,
  input bqsmx_pkg::bqsmx_frame_s out_o,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import bqsmx_pkg::*;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // Read data only in its slot, unmapped page 1 reads zero
  property p_rd_idle;
    !bus_i.rd |=> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_unmapped;
    bus_i.rd && bus_i.addr[15:8] == 8'h01 |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // Status register mirrors busy at the read strobe
  property p_status;
    bus_i.rd && bus_i.addr == {PAGE_CFG, REG_STATUS} |=> rdata_o == {7'h00, $past(busy_o)};
  endproperty
  a_status: assert property (p_status) else $error("status read not busy");

  // Accepted frame starts the engine, result within the stage budget
  property p_take;
    smp_valid_i && !busy_o |=> busy_o;
  endproperty
  a_take: assert property (p_take) else $error("frame not taken");
  property p_lat;
    smp_valid_i && !busy_o |-> ##[6:18] out_valid_o;
  endproperty
  a_lat: assert property (p_lat) else $error("result too late");
  property p_early;
    smp_valid_i && !busy_o |=> !out_valid_o [*5];
  endproperty
  a_early: assert property (p_early) else $error("result too early");

  // Result pulse and held frame
  property p_pulse;
    out_valid_o |=> !out_valid_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("valid longer than one cycle");
  property p_hold;
    !out_valid_o |-> $stable(out_o);
  endproperty
  a_hold: assert property (p_hold) else $error("output changed without valid");
  property p_end;
    out_valid_o |-> !busy_o && $past(busy_o);
  endproperty
  a_end: assert property (p_end) else $error("valid not at end of busy");
  property p_busy;
    $rose(busy_o) |-> busy_o [*5];
  endproperty
  a_busy: assert property (p_busy) else $error("busy too short");
endmodule

/* File: dv/tb_top.sv */
// Directed testbench for the biquad, summer and mixer chain
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bqsmx_pkg::*;

  localparam logic [31:0] HALF = 32'h40000000;
  localparam logic [31:0] QTR = 32'h20000000;
  localparam logic [31:0] NEG = 32'hC0000000;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic smp_valid_i = 1'b0;
  bqsmx_bus_s bus_i;
  bqsmx_frame_s smp_i = '0;
  bqsmx_frame_s out_o;
  bqsmx_frame_s f;
  logic [7:0] rdata_o;
  logic out_valid_o;
  logic busy_o;
  logic [7:0] rb;
  logic [31:0] y;
  logic [31:0] cm [4][4];
  logic [31:0] pulses;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;

  // Clock, 50 ns period
  always #25 sys_clk_i = ~sys_clk_i;

  bqsmx_host i_bqsmx_host (.sys_clk_i(sys_clk_i), .bus_o(bus_i), .rdata_i(rdata_o));
  bqsmx_chain i_bqsmx_chain (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .smp_valid_i(smp_valid_i), .smp_i(smp_i), .out_valid_o(out_valid_o), .out_o(out_o), .busy_o(busy_o));

  // Signed product and 1.31 rescale with clamp, kept apart from the design
  function automatic logic signed [63:0] prd(input logic [31:0] c, input logic [31:0] x);
    return $signed({{32{c[31]}}, c}) * $signed({{32{x[31]}}, x});
  endfunction
  function automatic logic [31:0] q(input logic signed [63:0] acc);
    logic signed [63:0] v;
    v = acc >>> 31;
    if (v > 64'sh7FFFFFFF) return 32'h7FFFFFFF;
    if (v < -64'sh80000000) return 32'h80000000;
    return v[31:0];
  endfunction
  function automatic logic [31:0] u(input logic [31:0] x);
    return q(prd(COEF_UNITY, x));
  endfunction
  function automatic logic [31:0] avg(input logic [31:0] a, input logic [31:0] b);
    logic signed [32:0] s;
    s = $signed({a[31], a}) + $signed({b[31], b});
    return 32'(s >>> 1);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    i_bqsmx_host.rd(a, rb);
    check($sformatf("reg %h", a), {24'h0, rb}, {24'h0, exp});
  endtask
  task automatic do_reset();
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
  endtask
  // Frame in, then wait bounded for the result pulse
  task automatic send(input bqsmx_frame_s fr);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    smp_valid_i <= 1'b1;
    smp_i <= fr;
    @(posedge sys_clk_i);
    smp_valid_i <= 1'b0;
    #1;
    while (out_valid_o !== 1'b1 && n < 40)
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    check("out_valid", {31'h0, out_valid_o}, 32'h1);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  initial
  begin
    f.ch[0] = 32'd1000;
    f.ch[1] = -32'sd1000;
    f.ch[2] = 32'h0;
    f.ch[3] = 32'h7FFFFFF0;
    do_reset();
    rdchk(16'h0208, 8'h7F);
    rdchk(16'h020B, 8'hFF);
    rdchk(16'h020C, 8'h00);
    rdchk(16'h036C, 8'h7F);
    rdchk(16'h006C, 8'h40);
    rdchk(16'h006B, 8'h00);
    rdchk(16'h0180, 8'h00);
    send(f);
    for (int c = 0; c < 4; c++) check("dflt", out_o.ch[c], u(u(u(f.ch[c]))));
    $display("test reset defaults done");
    i_bqsmx_host.wr(16'h006C, 8'h00);
    send(f);
    for (int c = 0; c < 4; c++) check("bypass", out_o.ch[c], u(f.ch[c]));
    $display("test bypass done");
    // Section 1 and 5 halve, section 9 halves with sign flip
    i_bqsmx_host.wr32(16'h0208, HALF);
    i_bqsmx_host.wr32(16'h0258, HALF);
    i_bqsmx_host.wr32(16'h0330, NEG);
    rdchk(16'h0330, 8'hC0);
    i_bqsmx_host.wr(16'h006C, 8'h20);
    send(f);
    check("one sect", out_o.ch[0], q(prd(HALF, u(f.ch[0]))));
    check("one sect ch2", out_o.ch[1], u(u(f.ch[1])));
    i_bqsmx_host.wr(16'h006C, 8'h60);
    send(f);
    check("three sect", out_o.ch[0], q(prd(NEG, q(prd(HALF, q(prd(HALF, u(f.ch[0]))))))));
    $display("test allocation done");
    // Recursive taps on section 2 with clean history
    do_reset();
    i_bqsmx_host.wr32(16'h021C, HALF);
    i_bqsmx_host.wr32(16'h0220, QTR);
    i_bqsmx_host.wr32(16'h0228, QTR);
    i_bqsmx_host.wr(16'h006C, 8'h20);
    send(f);
    y = q(prd(HALF, u(f.ch[1])));
    check("bq first", out_o.ch[1], y);
    send(f);
    check("bq second", out_o.ch[1], q(prd(HALF, u(f.ch[1])) + 2 * prd(QTR, u(f.ch[1])) + 2 * prd(QTR, y)));
    $display("test recursion done");
    // Mixer matrix with halves, inversion, mute and an overflowing row
    do_reset();
    i_bqsmx_host.wr(16'h006C, 8'h00);
    for (int m = 0; m < 4; m++) for (int j = 0; j < 4; j++) cm[m][j] = (m == j) ? COEF_UNITY : COEF_ZERO;
    cm[0] = '{HALF, NEG, COEF_ZERO, COEF_UNITY};
    cm[1] = '{COEF_UNITY, COEF_UNITY, COEF_UNITY, COEF_UNITY};
    cm[2] = '{COEF_ZERO, QTR, COEF_ZERO, COEF_ZERO};
    for (int m = 0; m < 4; m++) for (int j = 0; j < 4; j++) i_bqsmx_host.wr32(16'h0408 + 16'(16 * m + 4 * j), cm[m][j]);
    f.ch[0] = HALF;
    f.ch[1] = HALF;
    f.ch[3] = HALF;
    send(f);
    for (int m = 0; m < 4; m++)
    begin
      y = q(prd(cm[m][0], f.ch[0]) + prd(cm[m][1], f.ch[1]) + prd(cm[m][2], f.ch[2])
        + prd(cm[m][3], f.ch[3]));
      check("mixer", out_o.ch[m], y);
    end
    $display("test mixer done");
    // Pair averaging overrides the programmed mixer
    i_bqsmx_host.wr(16'h006B, 8'h04);
    rdchk(16'h006B, 8'h04);
    f.ch[0] = -32'sd3;
    f.ch[1] = 32'd4;
    f.ch[2] = 32'h40000000;
    f.ch[3] = 32'h40000001;
    send(f);
    check("avg 1", out_o.ch[0], avg(f.ch[0], f.ch[1]));
    check("avg 2", out_o.ch[1], avg(f.ch[0], f.ch[1]));
    check("avg 3", out_o.ch[2], avg(f.ch[2], f.ch[3]));
    check("avg 4", out_o.ch[3], avg(f.ch[2], f.ch[3]));
    // Busy in status mid-frame, and a frame offered while busy is dropped
    @(posedge sys_clk_i);
    smp_valid_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    smp_valid_i <= 1'b0;
    i_bqsmx_host.rd(16'h006D, rb);
    check("busy", {24'h0, rb}, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    #1;
    check("pulse", {31'h0, out_valid_o}, 32'h1);
    check("avg again", out_o.ch[0], avg(f.ch[0], f.ch[1]));
    pulses = 0;
    repeat (12)
    begin
      @(posedge sys_clk_i);
      #1;
      pulses += {31'h0, out_valid_o};
    end
    check("dropped", pulses, 32'h0);
    rdchk(16'h006D, 8'h00);
    $display("test averaging done");
    close_out();
  end
endmodule

bind bqsmx_chain bqsmx_checker i_bqsmx_checker (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .smp_valid_i(smp_valid_i), .out_valid_o(out_valid_o), .out_o(out_o), .busy_o(busy_o));
